/* File: common/ppm_pkg.sv */
// constants and types shared by the port pin mux and strap decoder
package ppm_pkg;

  // ---------------------------------------------------------------
  // pins and groups
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 16;
  localparam int FLAG_GROUPS = 4;
  localparam int FLAGS_PER_GROUP = 4;
  localparam int HALF_PINS = 8;

  // ---------------------------------------------------------------
  // sequence timing, in core clock cycles
  // ---------------------------------------------------------------
  localparam logic [2:0] ALE_CYCLES = 3'h1;
  // strobe outlasts the two-stage pin synchroniser before read capture
  localparam logic [2:0] STROBE_CYCLES = 3'h4;

  // clock generator lock wait after reset release
  localparam int LOCK_REF_CYCLES = 4096;
  localparam logic [12:0] LOCK_COUNT = 13'(LOCK_REF_CYCLES);

  // ---------------------------------------------------------------
  // strap codes
  // ---------------------------------------------------------------
  localparam logic [1:0] BOOT_SPI_SLAVE = 2'h0;
  localparam logic [1:0] BOOT_SPI_MASTER = 2'h1;
  localparam logic [1:0] BOOT_PARALLEL = 2'h2;
  localparam logic [1:0] STRAP_RESERVED = 2'h3;

  localparam logic [1:0] RATIO_CODE_6 = 2'h0;
  localparam logic [1:0] RATIO_CODE_32 = 2'h1;
  localparam logic [1:0] RATIO_CODE_16 = 2'h2;

  localparam logic [5:0] MULT_6 = 6'h06;
  localparam logic [5:0] MULT_32 = 6'h20;
  localparam logic [5:0] MULT_16 = 6'h10;

  // ---------------------------------------------------------------
  // reset values and pin enable patterns
  // ---------------------------------------------------------------
  localparam logic [15:0] PIN_RELEASED = 16'hffff;
  localparam logic [15:0] PIN_DRIVEN = 16'h0000;
  localparam logic [15:0] PIN_LOW_RELEASED = 16'h00ff;
  localparam logic [5:0] MULT_RESET = 6'h06;
  localparam logic [3:0] DIV_RESET = 4'h1;

  // ---------------------------------------------------------------
  // access sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PPM_IDLE = 4'b0001,
    PPM_ADDR = 4'b0010,
    PPM_STRB = 4'b0100,
    PPM_DONE = 4'b1000
  } ppm_state_t;

endpackage : ppm_pkg

/* File: verilog/ppm_strap_decode.sv */
// strap synchroniser, capture after reset release and decode
`timescale 1ns/1ns
`default_nettype none

module ppm_strap_decode
  import ppm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] boot_select_straps,
  input wire logic [1:0] core_ratio_straps,
  output logic strap_valid_ff,
  output logic [1:0] boot_mode_ff,
  output logic boot_reserved_ff,
  output logic [5:0] strap_mult_ff,
  output logic ratio_reserved_ff
);

  logic [3:0] strap_meta_ff;
  logic [3:0] strap_sync_ff;
  logic [1:0] settle_ff;

  // straps come from pins: two stages before any decoding
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strap_meta_ff <= 4'h0;
      strap_sync_ff <= 4'h0;
    end else begin
      strap_meta_ff <= {boot_select_straps, core_ratio_straps};
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // capture once, after the synchroniser has filled
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      settle_ff <= 2'h0;
      strap_valid_ff <= 1'b0;
      boot_mode_ff <= BOOT_SPI_SLAVE;
      boot_reserved_ff <= 1'b0;
      strap_mult_ff <= MULT_RESET;
      ratio_reserved_ff <= 1'b0;
    end else if (!strap_valid_ff) begin
      settle_ff <= settle_ff + 2'h1;
      if (settle_ff == 2'h2) begin
        strap_valid_ff <= 1'b1;
        boot_mode_ff <= strap_sync_ff[3:2]; // [RULE10]
        boot_reserved_ff <= (strap_sync_ff[3:2] == STRAP_RESERVED); // [RULE12]
        ratio_reserved_ff <= (strap_sync_ff[1:0] == STRAP_RESERVED); // [RULE12]
        unique case (strap_sync_ff[1:0]) // [RULE11]
          RATIO_CODE_6: strap_mult_ff <= MULT_6;
          RATIO_CODE_32: strap_mult_ff <= MULT_32;
          RATIO_CODE_16: strap_mult_ff <= MULT_16;
          // reserved code: nothing defined, fall back to the slowest ratio
          default: strap_mult_ff <= MULT_RESET; // [RULE12]
        endcase
      end
    end
  end

endmodule : ppm_strap_decode

`default_nettype wire

/* File: verilog/ppm_pin_mux.sv */
// multiplexed address/data pin control, flag mapping and start-up clocking
// Function
// RULE1 - disable bit frees pins from parallel port
// RULE2 - software enables flag groups after disabling
// RULE3 - pin n maps to flag n+8 or n-8
// RULE4 - 8-bit, ale high: A23-16 high, A15-8 low
// RULE5 - 8-bit, ale low: A7-0 high, D7-0 low
// RULE6 - 16-bit, ale high: A15-0 on pins
// RULE7 - 16-bit, ale low: D15-0 on pins
// RULE8 - external latch holds address from ale fall
// RULE9 - strobes released only during reset
// RULE10 - boot straps: slave, master, parallel eprom
// RULE11 - ratio straps: 6, 32, 16 multiplication
// RULE12 - strap code 11 is reserved
// RULE13 - wait 4096 clocks for lock before run
// RULE14 - straps set start-up ratio only
`timescale 1ns/1ns
`default_nettype none

module ppm_pin_mux
  import ppm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  // system control bits
  input wire logic pp_disable,
  input wire logic [3:0] flag_group_en,
  input wire logic [15:0] flag_dir,
  input wire logic [15:0] flag_wdata,
  output logic [15:0] flag_rdata_ff,
  // parallel port access requests
  input wire logic pp_req,
  input wire logic pp_write,
  input wire logic pp_wide,
  input wire logic [23:0] pp_addr,
  input wire logic [15:0] pp_wdata,
  output logic [15:0] pp_rdata_ff,
  output logic pp_done_ff,
  output logic pp_busy_ff,
  // multiplexed address/data pins
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out_ff,
  output logic [15:0] ad_oe_n_ff,
  // strobes
  output logic ale_ff,
  output logic rd_n_ff,
  output logic wr_n_ff,
  output logic strobe_oe_n_ff,
  // straps and clock control
  input wire logic [1:0] boot_select_straps,
  input wire logic [1:0] core_ratio_straps,
  input wire logic pll_ctl_wr,
  input wire logic [5:0] pll_ctl_mult,
  input wire logic [3:0] pll_ctl_div,
  output logic [1:0] boot_mode_ff,
  output logic strap_reserved_ff,
  output logic [5:0] core_mult_ff,
  output logic [3:0] core_div_ff,
  output logic core_run_ff
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // flag number carried by a pin; the mapping is its own inverse
  function automatic logic [3:0] pin_flag(input logic [3:0] pin);
    pin_flag = pin ^ 4'h8; // [RULE3]
  endfunction : pin_flag

  ppm_state_t state_ff;
  ppm_state_t nxt_state;
  logic [2:0] phase_cnt_ff;
  logic [23:0] addr_ff;
  logic [15:0] wdata_ff;
  logic write_ff;
  logic wide_ff;
  logic [15:0] ad_meta_ff;
  logic [15:0] ad_sync_ff;
  logic [15:0] port_out;
  logic [15:0] port_oe_n;
  logic [15:0] nxt_ad_out;
  logic [15:0] nxt_ad_oe_n;
  logic [12:0] lock_cnt_ff;
  logic strap_valid;
  logic strap_seen_ff;
  logic [1:0] boot_mode;
  logic boot_rsvd;
  logic ratio_rsvd;
  logic [5:0] strap_mult;
  logic phase_end;

  // ---------------------------------------------------------------
  // straps and start-up clocking
  // ---------------------------------------------------------------
  ppm_strap_decode u_strap (
    .core_clk(core_clk),
    .rstn(rstn),
    .boot_select_straps(boot_select_straps),
    .core_ratio_straps(core_ratio_straps),
    .strap_valid_ff(strap_valid),
    .boot_mode_ff(boot_mode),
    .boot_reserved_ff(boot_rsvd),
    .strap_mult_ff(strap_mult),
    .ratio_reserved_ff(ratio_rsvd)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_mode_ff <= BOOT_SPI_SLAVE;
      strap_reserved_ff <= 1'b0;
    end else begin
      boot_mode_ff <= boot_mode; // [RULE10]
      strap_reserved_ff <= boot_rsvd | ratio_rsvd; // [RULE12]
    end
  end

  // straps seed the multiplier once; later writes always win
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strap_seen_ff <= 1'b0;
      core_mult_ff <= MULT_RESET;
      core_div_ff <= DIV_RESET;
    end else if (pll_ctl_wr) begin
      core_mult_ff <= pll_ctl_mult; // [RULE14]
      core_div_ff <= pll_ctl_div; // [RULE14]
      strap_seen_ff <= strap_valid;
    end else if (strap_valid && !strap_seen_ff) begin
      strap_seen_ff <= 1'b1;
      core_mult_ff <= strap_mult; // [RULE14]
    end
  end

  // core held off until the lock wait has run out
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lock_cnt_ff <= 13'h0;
      core_run_ff <= 1'b0;
    end else if (lock_cnt_ff != LOCK_COUNT) begin
      lock_cnt_ff <= lock_cnt_ff + 13'h1; // [RULE13]
    end else begin
      core_run_ff <= 1'b1; // [RULE13]
    end
  end

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ad_meta_ff <= 16'h0000;
      ad_sync_ff <= 16'h0000;
    end else begin
      ad_meta_ff <= ad_in;
      ad_sync_ff <= ad_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  assign phase_end = (state_ff == PPM_ADDR) ? (phase_cnt_ff == ALE_CYCLES - 3'h1)
                                            : (phase_cnt_ff == STROBE_CYCLES - 3'h1);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PPM_IDLE: begin
        if (pp_req && !pp_disable && core_run_ff) begin // [RULE1]
          nxt_state = PPM_ADDR;
        end
      end
      PPM_ADDR: begin
        if (phase_end) begin
          nxt_state = PPM_STRB;
        end
      end
      PPM_STRB: begin
        if (phase_end) begin
          nxt_state = PPM_DONE;
        end
      end
      PPM_DONE: nxt_state = PPM_IDLE;
      default: nxt_state = PPM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= PPM_IDLE;
      phase_cnt_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      phase_cnt_ff <= (nxt_state != state_ff) ? 3'h0 : phase_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      addr_ff <= 24'h000000;
      wdata_ff <= 16'h0000;
      write_ff <= 1'b0;
      wide_ff <= 1'b0;
    end else if (state_ff == PPM_IDLE && nxt_state == PPM_ADDR) begin
      addr_ff <= pp_addr;
      wdata_ff <= pp_wdata;
      write_ff <= pp_write;
      wide_ff <= pp_wide;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pp_rdata_ff <= 16'h0000;
      pp_done_ff <= 1'b0;
      pp_busy_ff <= 1'b0;
    end else begin
      pp_done_ff <= (nxt_state == PPM_DONE);
      pp_busy_ff <= (nxt_state != PPM_IDLE);
      if (state_ff == PPM_STRB && phase_end && !write_ff) begin
        pp_rdata_ff <= wide_ff ? ad_sync_ff : {8'h00, ad_sync_ff[7:0]};
      end
    end
  end

  // strobes: released only while reset is held
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strobe_oe_n_ff <= 1'b1; // [RULE9]
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      strobe_oe_n_ff <= 1'b0; // [RULE9]
      // ale drops in the same cycle the strobe asserts, after the latch has taken the settled address
      ale_ff <= (nxt_state == PPM_ADDR); // [RULE8]
      rd_n_ff <= !(nxt_state == PPM_STRB && !write_ff);
      wr_n_ff <= !(nxt_state == PPM_STRB && write_ff);
    end
  end

  // ---------------------------------------------------------------
  // pin values per phase, computed for the next cycle
  // ---------------------------------------------------------------
  always_comb begin
    port_out = 16'h0000;
    port_oe_n = PIN_RELEASED;
    if (nxt_state == PPM_ADDR) begin
      port_oe_n = PIN_DRIVEN;
      if (pp_wide) begin
        port_out = pp_addr[15:0]; // [RULE6]
      end else begin
        port_out = pp_addr[23:8]; // [RULE4]
      end
    end else if (nxt_state == PPM_STRB) begin
      if (wide_ff) begin
        port_out = wdata_ff; // [RULE7]
        port_oe_n = write_ff ? PIN_DRIVEN : PIN_RELEASED; // [RULE7]
      end else begin
        port_out = {addr_ff[7:0], wdata_ff[7:0]}; // [RULE5]
        port_oe_n = write_ff ? PIN_DRIVEN : PIN_LOW_RELEASED; // [RULE5]
      end
    end
  end

  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      localparam logic [3:0] FLG = pin_flag(4'(p));
      always_comb begin
        nxt_ad_out[p] = port_out[p];
        nxt_ad_oe_n[p] = port_oe_n[p];
        if (pp_disable) begin // [RULE1]
          nxt_ad_out[p] = flag_wdata[FLG]; // [RULE3]
          // unenabled groups float so nothing fights the board
          nxt_ad_oe_n[p] = !(flag_group_en[FLG[3:2]] && flag_dir[FLG]); // [RULE2]
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ad_out_ff <= 16'h0000;
      ad_oe_n_ff <= PIN_RELEASED;
      flag_rdata_ff <= 16'h0000;
    end else begin
      ad_out_ff <= nxt_ad_out;
      ad_oe_n_ff <= nxt_ad_oe_n;
      flag_rdata_ff <= {ad_sync_ff[7:0], ad_sync_ff[15:8]}; // [RULE3]
    end
  end

endmodule : ppm_pin_mux

`default_nettype wire

/* File: sim/ppm_pin_mux_sva.sv */
// concurrent checks on the pin mux top-level ports
`timescale 1ns/1ns
`default_nettype none

module ppm_pin_mux_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pp_disable,
  input wire logic [3:0] flag_group_en,
  input wire logic [15:0] flag_dir,
  input wire logic [15:0] flag_wdata,
  input wire logic pp_write,
  input wire logic pp_wide,
  input wire logic [23:0] pp_addr,
  input wire logic [15:0] pp_wdata,
  input wire logic pp_done_ff,
  input wire logic [15:0] ad_out_ff,
  input wire logic [15:0] ad_oe_n_ff,
  input wire logic ale_ff,
  input wire logic rd_n_ff,
  input wire logic wr_n_ff,
  input wire logic strobe_oe_n_ff,
  input wire logic core_run_ff
);
  logic [12:0] wait_cnt_ff;
  logic [15:0] grp_mask;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // group enables seen in pin order, since pin p serves flag p^8
  assign grp_mask = {{4{flag_group_en[1]}}, {4{flag_group_en[0]}},
                     {4{flag_group_en[3]}}, {4{flag_group_en[2]}}};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wait_cnt_ff <= 13'h0000;
    end else if (wait_cnt_ff != 13'h1fff) begin
      wait_cnt_ff <= wait_cnt_ff + 13'h0001;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_strobe_driven: assert property (rstn |=> !strobe_oe_n_ff)
    else $error("strobe pins released out of reset");
  a_ale_one_cycle: assert property ($rose(ale_ff) |=> !ale_ff && !(rd_n_ff && wr_n_ff))
    else $error("latch strobe not followed by access strobe");
  a_done_timing: assert property ($rose(ale_ff) |-> ##5 pp_done_ff)
    else $error("access did not finish on time");
  a_addr_narrow: assert property ($rose(ale_ff) && !$past(pp_disable) && !$past(pp_wide)
    |-> ad_out_ff == $past(pp_addr[23:8]) && ad_oe_n_ff == 16'h0000)
    else $error("narrow address phase wrong");
  a_addr_wide: assert property ($rose(ale_ff) && !$past(pp_disable) && $past(pp_wide)
    |-> ad_out_ff == $past(pp_addr[15:0]) && ad_oe_n_ff == 16'h0000)
    else $error("wide address phase wrong");
  a_data_narrow: assert property ($rose(ale_ff) && !pp_disable && !$past(pp_wide) && $past(pp_write)
    |=> ad_out_ff == {$past(pp_addr[7:0], 2), $past(pp_wdata[7:0], 2)})
    else $error("narrow data phase wrong");
  a_data_wide: assert property ($rose(ale_ff) && !pp_disable && $past(pp_wide) && $past(pp_write)
    |=> ad_out_ff == $past(pp_wdata, 2) && ad_oe_n_ff == 16'h0000)
    else $error("wide data phase wrong");
  a_flag_enable: assert property ($past(pp_disable) && $past(rstn) |-> ad_oe_n_ff ==
    ~($past(grp_mask) & {$past(flag_dir[7:0]), $past(flag_dir[15:8])}))
    else $error("flag pin enables wrong");
  a_flag_map: assert property ($past(pp_disable) && $past(rstn) |-> ((ad_out_ff ^
    {$past(flag_wdata[7:0]), $past(flag_wdata[15:8])}) & ~ad_oe_n_ff) == 16'h0000)
    else $error("flag pin values wrong");
  a_lock_wait: assert property ($rose(core_run_ff) |-> wait_cnt_ff == 13'h1001)
    else $error("core started at wrong time");
endmodule : ppm_pin_mux_sva

bind ppm_pin_mux ppm_pin_mux_sva u_sva (.*);

`default_nettype wire

/* File: sim/ppm_mem_model.sv */
// external address latch and memory on the multiplexed pins
`timescale 1ns/1ns
`default_nettype none

module ppm_mem_model (
  input wire logic core_clk,
  input wire logic ale_ff,
  input wire logic rd_n_ff,
  input wire logic wr_n_ff,
  input wire logic [15:0] ad_out_ff,
  input wire logic [15:0] ad_oe_n_ff,
  output logic [15:0] ad_in,
  output logic [15:0] lat_ff,
  output logic [15:0] wr_seen_ff
);
  // released pins sit at the pull-up level unless the memory answers a read
  assign ad_in = (ad_out_ff & ~ad_oe_n_ff)
               | (ad_oe_n_ff & (rd_n_ff ? 16'hffff : lat_ff ^ 16'ha5c3));

  always_ff @(posedge core_clk) begin
    if (ale_ff) begin
      lat_ff <= ad_in; // transparent while high, holds from the fall
    end
    if (!wr_n_ff) begin
      wr_seen_ff <= ad_in;
    end
  end
endmodule : ppm_mem_model

`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the port pin mux
`timescale 1ns/1ns
`default_nettype none

module tb;
  import ppm_pkg::*;
  logic core_clk, rstn, pp_disable, pp_req, pp_write, pp_wide, pll_ctl_wr;
  logic pp_done_ff, pp_busy_ff, ale_ff, rd_n_ff, wr_n_ff, strobe_oe_n_ff;
  logic strap_reserved_ff, core_run_ff;
  logic [3:0] flag_group_en, pll_ctl_div, core_div_ff;
  logic [15:0] flag_dir, flag_wdata, pp_wdata, ad_in, flag_rdata_ff, pp_rdata_ff;
  logic [15:0] ad_out_ff, ad_oe_n_ff, lat_ff, wr_seen_ff;
  logic [23:0] pp_addr;
  logic [5:0] pll_ctl_mult, core_mult_ff;
  logic [1:0] boot_select_straps, core_ratio_straps, boot_mode_ff;
  int n_fail, n_tests;
  // write, wide, address, write data, expected latch, expected data
  localparam logic [73:0] ROWS [4] = '{
    {1'h1, 1'h1, 24'h00a55a, 16'h8001, 16'ha55a, 16'h8001},
    {1'h1, 1'h0, 24'hfedcba, 16'h0042, 16'hfedc, 16'hba42},
    {1'h0, 1'h1, 24'h00ffff, 16'h0000, 16'hffff, 16'h5a3c},
    {1'h0, 1'h0, 24'h123456, 16'h0000, 16'h1234, 16'h00f7}};
  localparam logic [5:0] MULTS [4] = '{MULT_6, MULT_32, MULT_16, MULT_6};

  ppm_pin_mux dut (.*);
  ppm_mem_model mem (.*);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic wait_for(ref logic sig, input int lim);
    int k;
    k = 0;
    while (sig !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    if (k >= lim) begin
      chk(16'h0000, 16'h0001);
    end
  endtask : wait_for

  task automatic do_reset();
    rstn <= 1'b0;
    tick(16);
    chk({15'h0000, strobe_oe_n_ff}, 16'h0001);
    chk(ad_oe_n_ff, PIN_RELEASED);
    rstn <= 1'b1;
  endtask : do_reset

  task automatic access(input logic [73:0] r);
    pp_write <= r[73];
    pp_wide <= r[72];
    pp_addr <= r[71:48];
    pp_wdata <= r[47:32];
    pp_req <= 1'b1;
    tick(1);
    wait_for(pp_busy_ff, 20);
    // dropped once taken so the same row is not run twice
    pp_req <= 1'b0;
    wait_for(pp_done_ff, 20);
    chk(lat_ff, r[31:16]);
    chk(r[73] ? wr_seen_ff : pp_rdata_ff, r[15:0]);
  endtask : access

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #(40 * 6000);
    n_fail++;
    test_done();
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    {rstn, pp_disable, pp_req, pp_write, pp_wide, pll_ctl_wr} = 6'h00;
    {flag_group_en, flag_dir, flag_wdata, pp_wdata, pp_addr} = 76'h0;
    {pll_ctl_div, pll_ctl_mult, boot_select_straps, core_ratio_straps} = 14'h0000;
    for (int c = 0; c < 4; c++) begin
      boot_select_straps <= 2'(c);
      core_ratio_straps <= 2'(3 - c);
      do_reset();
      tick(6);
      chk({14'h0000, boot_mode_ff}, 16'(c));
      chk({15'h0000, strap_reserved_ff}, 16'(c == 0 || c == 3));
      chk({10'h000, core_mult_ff}, {10'h000, MULTS[3 - c]});
      chk({12'h000, core_div_ff}, {12'h000, DIV_RESET});
    end
    // requests before the lock wait ends must be ignored
    pp_req <= 1'b1;
    tick(8);
    chk({15'h0000, pp_busy_ff}, 16'h0000);
    pp_req <= 1'b0;
    wait_for(core_run_ff, 4200);
    for (int i = 0; i < 4; i++) begin
      access(ROWS[i]);
    end
    pp_disable <= 1'b1;
    flag_group_en <= 4'h5;
    flag_dir <= 16'hffff;
    flag_wdata <= 16'h1234;
    pp_req <= 1'b1;
    tick(6);
    chk(ad_oe_n_ff, 16'hf0f0);
    chk(ad_out_ff & 16'h0f0f, 16'h0402);
    chk(flag_rdata_ff, 16'hf2f4);
    chk({15'h0000, pp_busy_ff}, 16'h0000);
    pp_req <= 1'b0;
    pp_disable <= 1'b0;
    pll_ctl_wr <= 1'b1;
    pll_ctl_mult <= 6'h0c;
    pll_ctl_div <= 4'h3;
    tick(1);
    pll_ctl_wr <= 1'b0;
    tick(3);
    chk({6'h00, core_div_ff, core_mult_ff}, 16'h00cc);
    do_reset();
    tick(4);
    test_done();
  end
endmodule : tb

`default_nettype wire
